// File: src/rrs_pkg.sv
package rrs_pkg;

  // clock and timing
  localparam int CLK_MHZ            = 250;
  localparam int CLK_PERIOD_NS      = 4;
  localparam int CLOCK_MONITOR_STARTUP_DELAY_US = 100;
  localparam int CLOCK_MONITOR_STARTUP_DELAY_CYC =
    (CLOCK_MONITOR_STARTUP_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int POWER_ON_TIMEOUT_CYC_DEF   = 2048;
  localparam int POWER_UP_TIMEOUT_CYC_DEF   = 16384;
  localparam int OSC_STARTUP_CYC_DEF        = 1024;
  localparam int CNT_W                      = 32;

  // register map (word addresses on the plain port)
  localparam int ADDR_W    = 4;
  localparam int DATA_W    = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_IRQ    = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_RCTRL  = 4'h4;

  // control register fields
  localparam int CTRL_MON_EN_BIT   = 0;
  localparam int CTRL_PUT_EN_BIT   = 1;
  localparam int CTRL_BRN_EN_BIT   = 2;
  localparam int CTRL_SRC_LSB      = 4;
  localparam int CTRL_MODE_LSB     = 8;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0007;

  // reset control register fields
  localparam int RCTRL_BRN_FLAG_BIT = 1;
  localparam int RCTRL_POR_FLAG_BIT = 0;

  // event bits in status / mask
  localparam int EV_W          = 3;
  localparam int EV_CLK_FAIL   = 0;
  localparam int EV_BROWN_OUT  = 1;
  localparam int EV_RST_DONE   = 2;

  // oscillator source select codes
  localparam logic [2:0] SRC_PRIMARY = 3'h3;
  localparam logic [2:0] SRC_FAST_RC = 3'h1;
  localparam logic [2:0] SRC_SLOW_RC = 3'h2;
  localparam logic [2:0] SRC_EXT_RC  = 3'h0;
  localparam logic [2:0] SRC_EXT_CLK = 3'h4;
  // primary mode field: bit 4 marks pll use, bit 3 marks a crystal
  localparam int MODE_PLL_BIT  = 4;
  localparam int MODE_XTAL_BIT = 3;

  // sequencer states
  typedef enum logic [5:0] {
    RRS_POR     = 6'h01,
    RRS_TIMERS  = 6'h02,
    RRS_MONDLY  = 6'h04,
    RRS_CLKWAIT = 6'h08,
    RRS_RUN     = 6'h10,
    RRS_BROWN   = 6'h20
  } rrs_state_e;

  // configuration carried as one bundle
  typedef struct packed {
    logic       mon_en;
    logic       put_en;
    logic       brn_en;
    logic [2:0] osc_source_select_cfg;
    logic [4:0] primary_osc_mode_cfg;
  } rrs_cfg_s;

  // oscillator status bundle
  typedef struct packed {
    logic osc_running;
    logic pll_lock;
  } rrs_osc_s;

endpackage

// File: src/rrs_timer.sv
// down counter that raises its expiry flag once it stops and holds it until the next start
module rrs_timer (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      ce,
  // control
  input  wire logic                      start,
  input  wire logic [rrs_pkg::CNT_W-1:0] load,
  // status
  output logic                           done
);

  logic [rrs_pkg::CNT_W-1:0] count;
  logic                      busy;

  // reload on start, count down to one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 32'h0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (ce) begin
      if (start) begin
        count <= load;
        busy  <= 1'b1;
        done  <= 1'b0;
      end else if (busy) begin
        if (count <= 32'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 32'h1;
        end
      end
    end
  end

endmodule // rrs_timer

// File: src/rrs_sequencer.sv
// Notes on behaviour
// - reset timers run without waiting on oscillator, start-up timer or pll.
// - with monitor on, clock not ready after timers gives trap and fast rc.
// - monitor and power-up timer off: leave reset at once; rc/ext clocks ready.
// - monitor off and no clock: stay held in reset until clock appears.
// - brown-out pulses reset, then selects source from configuration fields.
// - oscillator mode after brown-out starts start-up timer, withholds clock.
// - with pll, clock withheld until lock bit in oscillator control reads one.
// - both timeouts elapse; crystal without power-up timer adds 100 us delay.
// - brown-out sets bit 1 of the reset control register.
// - brown-out detector keeps working in sleep and idle.
//
// Chosen here: the address-and-strobe port and the register offsets.
module rrs_sequencer #(
  parameter int POWER_ON_CYC  = rrs_pkg::POWER_ON_TIMEOUT_CYC_DEF,
  parameter int POWER_UP_CYC  = rrs_pkg::POWER_UP_TIMEOUT_CYC_DEF,
  parameter int OSC_START_CYC = rrs_pkg::OSC_STARTUP_CYC_DEF,
  parameter int MON_DLY_CYC   = rrs_pkg::CLOCK_MONITOR_STARTUP_DELAY_CYC
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       ce,
  // supply and oscillator status
  input  wire logic                       brown_out_trip,
  input  wire logic                       sleep_idle,
  input  wire rrs_pkg::rrs_osc_s          osc_stat,
  // register port
  input  wire logic [rrs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [rrs_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic [rrs_pkg::DATA_W-1:0]      reg_rdata,
  // outputs
  output logic                            internal_reset,
  output logic                            sys_clk_en,
  output logic                            use_fast_internal_rc_osc,
  output logic                            clk_fail_trap,
  output logic                            irq
);

  rrs_pkg::rrs_state_e       state;
  rrs_pkg::rrs_state_e       next_state;
  rrs_pkg::rrs_cfg_s         cfg;
  logic [rrs_pkg::DATA_W-1:0] ctrl;
  logic [rrs_pkg::EV_W-1:0]  irq_stat;
  logic [rrs_pkg::EV_W-1:0]  irq_mask;
  logic [rrs_pkg::EV_W-1:0]  ev;
  logic                      brn_flag;
  logic                      por_flag;
  logic                      brn_seen;
  logic                      por_start;
  logic                      put_start;
  logic                      mon_start;
  logic                      sut_start;
  logic                      por_done;
  logic                      put_done;
  logic                      mon_done;
  logic                      sut_done;
  logic                      timers_done;
  logic                      clk_ready;
  logic                      brn_event;

  // decode helpers used by several processes
  function automatic logic is_osc_mode(input rrs_pkg::rrs_cfg_s c);
    return c.osc_source_select_cfg == rrs_pkg::SRC_PRIMARY;
  endfunction

  function automatic logic is_xtal(input rrs_pkg::rrs_cfg_s c);
    return is_osc_mode(c) && c.primary_osc_mode_cfg[rrs_pkg::MODE_XTAL_BIT];
  endfunction

  function automatic logic uses_pll(input rrs_pkg::rrs_cfg_s c);
    return is_osc_mode(c) && c.primary_osc_mode_cfg[rrs_pkg::MODE_PLL_BIT];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration from control register
  always_comb begin
    cfg.mon_en   = ctrl[rrs_pkg::CTRL_MON_EN_BIT];
    cfg.put_en   = ctrl[rrs_pkg::CTRL_PUT_EN_BIT];
    cfg.brn_en   = ctrl[rrs_pkg::CTRL_BRN_EN_BIT];
    cfg.osc_source_select_cfg = ctrl[rrs_pkg::CTRL_SRC_LSB +: 3];
    cfg.primary_osc_mode_cfg  = ctrl[rrs_pkg::CTRL_MODE_LSB +: 5];
  end

  // detector active regardless of sleep or idle
  assign brn_event = cfg.brn_en && brown_out_trip;

  ////////////////////////////////////////////////////////////////////////////
  // timers
  rrs_timer u_por (
    .clk(clk), .nrst(nrst), .ce(ce), .start(por_start),
    .load(32'(POWER_ON_CYC)), .done(por_done)
  );
  rrs_timer u_put (
    .clk(clk), .nrst(nrst), .ce(ce), .start(put_start),
    .load(32'(POWER_UP_CYC)), .done(put_done)
  );
  rrs_timer u_mon (
    .clk(clk), .nrst(nrst), .ce(ce), .start(mon_start),
    .load(32'(MON_DLY_CYC)), .done(mon_done)
  );
  rrs_timer u_sut (
    .clk(clk), .nrst(nrst), .ce(ce), .start(sut_start),
    .load(32'(OSC_START_CYC)), .done(sut_done)
  );

  // reset timers start together, oscillator timer only in oscillator mode
  always_comb begin
    por_start  = (state == rrs_pkg::RRS_POR);
    put_start  = por_start && cfg.put_en;
    sut_start  = por_start && is_osc_mode(cfg);
    mon_start  = (state == rrs_pkg::RRS_TIMERS) && por_done && !cfg.put_en
                 && is_xtal(cfg) && timers_done;
  end

  // both timeouts must be elapsed; timers ignore oscillator status
  assign timers_done = por_done && (put_done || !cfg.put_en);

  // clock readiness: running, start-up timer out, pll locked
  always_comb begin
    if (is_osc_mode(cfg)) begin
      clk_ready = osc_stat.osc_running && sut_done
                  && (osc_stat.pll_lock || !uses_pll(cfg));
    end else begin
      clk_ready = osc_stat.osc_running;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      rrs_pkg::RRS_POR: begin
        if (!cfg.mon_en && !cfg.put_en && !is_osc_mode(cfg)) begin
          next_state = rrs_pkg::RRS_CLKWAIT;
        end else begin
          next_state = rrs_pkg::RRS_TIMERS;
        end
      end
      rrs_pkg::RRS_TIMERS: begin
        if (timers_done) begin
          if (!cfg.put_en && is_xtal(cfg)) begin
            next_state = rrs_pkg::RRS_MONDLY;
          end else begin
            next_state = rrs_pkg::RRS_CLKWAIT;
          end
        end
      end
      rrs_pkg::RRS_MONDLY: begin
        if (mon_done) begin
          next_state = rrs_pkg::RRS_CLKWAIT;
        end
      end
      rrs_pkg::RRS_CLKWAIT: begin
        if (clk_ready || cfg.mon_en) begin
          next_state = rrs_pkg::RRS_RUN;
        end
      end
      rrs_pkg::RRS_RUN: begin
        next_state = rrs_pkg::RRS_RUN;
      end
      rrs_pkg::RRS_BROWN: begin
        if (!brn_event) begin
          next_state = rrs_pkg::RRS_POR;
        end
      end
      default: next_state = rrs_pkg::RRS_POR;
    endcase
    if (brn_event) begin
      next_state = rrs_pkg::RRS_BROWN;
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= rrs_pkg::RRS_POR;
    end else if (ce) begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: reset held until run state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      internal_reset <= 1'b1;
      sys_clk_en     <= 1'b0;
    end else if (ce) begin
      internal_reset <= (next_state != rrs_pkg::RRS_RUN);
      sys_clk_en     <= (next_state == rrs_pkg::RRS_RUN)
                        && (clk_ready || use_fast_internal_rc_osc
                            || (state == rrs_pkg::RRS_CLKWAIT && !clk_ready
                                && cfg.mon_en));
    end
  end

  // clock-failure trap and fast rc fallback
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      use_fast_internal_rc_osc <= 1'b0;
      clk_fail_trap            <= 1'b0;
    end else if (ce) begin
      clk_fail_trap <= 1'b0;
      if (state == rrs_pkg::RRS_BROWN) begin
        use_fast_internal_rc_osc <= 1'b0;
      end else if (state == rrs_pkg::RRS_CLKWAIT && cfg.mon_en && !clk_ready
                   && !brn_event) begin
        use_fast_internal_rc_osc <= 1'b1;
        clk_fail_trap            <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset status flags: brown-out flag set wins over clear
  assign brn_seen = (state != rrs_pkg::RRS_BROWN) && brn_event;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      brn_flag <= 1'b0;
      por_flag <= 1'b1;
    end else if (ce) begin
      if (brn_seen) begin
        brn_flag <= 1'b1;
      end else if (reg_wr && reg_addr == rrs_pkg::ADDR_RCTRL) begin
        brn_flag <= reg_wdata[rrs_pkg::RCTRL_BRN_FLAG_BIT];
      end
      if (reg_wr && reg_addr == rrs_pkg::ADDR_RCTRL) begin
        por_flag <= reg_wdata[rrs_pkg::RCTRL_POR_FLAG_BIT];
      end
    end
  end

  // control register; not cleared by brown-out
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= rrs_pkg::CTRL_RESET;
    end else if (ce && reg_wr && reg_addr == rrs_pkg::ADDR_CTRL) begin
      ctrl <= reg_wdata;
    end
  end

  // sticky events, write one to clear, set wins
  always_comb begin
    ev = '0;
    ev[rrs_pkg::EV_CLK_FAIL]  = clk_fail_trap;
    ev[rrs_pkg::EV_BROWN_OUT] = brn_seen;
    ev[rrs_pkg::EV_RST_DONE]  = internal_reset
                                && next_state == rrs_pkg::RRS_RUN;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_stat <= 3'h0;
      irq_mask <= 3'h0;
    end else if (ce) begin
      if (reg_wr && reg_addr == rrs_pkg::ADDR_IRQ) begin
        irq_stat <= (irq_stat & ~reg_wdata[rrs_pkg::EV_W-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (reg_wr && reg_addr == rrs_pkg::ADDR_MASK) begin
        irq_mask <= reg_wdata[rrs_pkg::EV_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // read data one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0;
    end else if (ce) begin
      reg_rdata <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          rrs_pkg::ADDR_CTRL:   reg_rdata <= ctrl;
          rrs_pkg::ADDR_STATUS: reg_rdata <= {20'h0, sys_clk_en, internal_reset,
                                              osc_stat.pll_lock, osc_stat.osc_running,
                                              2'h0, state};
          rrs_pkg::ADDR_IRQ:    reg_rdata <= {29'h0, irq_stat};
          rrs_pkg::ADDR_MASK:   reg_rdata <= {29'h0, irq_mask};
          rrs_pkg::ADDR_RCTRL:  reg_rdata <= {30'h0, brn_flag, por_flag};
          default:              reg_rdata <= 32'h0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_RST_UNTIL_RUN: assert property (@(posedge clk) disable iff (!nrst)
    ce && state != rrs_pkg::RRS_RUN && next_state != rrs_pkg::RRS_RUN
    |=> internal_reset) else $error("reset released early");
  AST_BRN_FLAG: assert property (@(posedge clk) disable iff (!nrst)
    ce && brn_seen |=> brn_flag) else $error("brown-out flag not set");
  AST_BRN_RESET: assert property (@(posedge clk) disable iff (!nrst)
    ce && brn_event |=> internal_reset && state == rrs_pkg::RRS_BROWN)
    else $error("brown-out did not reset");
  AST_BRN_SLEEP: assert property (@(posedge clk) disable iff (!nrst)
    ce && sleep_idle && brn_event |=> state == rrs_pkg::RRS_BROWN)
    else $error("brown-out ignored in sleep");
  AST_TRAP_FRC: assert property (@(posedge clk) disable iff (!nrst)
    clk_fail_trap |-> use_fast_internal_rc_osc) else $error("trap without fallback");
  AST_NO_MON_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    ce && state == rrs_pkg::RRS_CLKWAIT && !cfg.mon_en && !clk_ready && !brn_event
    |=> state == rrs_pkg::RRS_CLKWAIT) else $error("left reset without clock");
  AST_TIMERS_FIRST: assert property (@(posedge clk) disable iff (!nrst)
    ce && state == rrs_pkg::RRS_TIMERS && !timers_done && !brn_event
    |=> state == rrs_pkg::RRS_TIMERS) else $error("timeouts skipped");
  AST_QUICK_EXIT: assert property (@(posedge clk) disable iff (!nrst)
    ce && state == rrs_pkg::RRS_POR && !brn_event && !cfg.mon_en && !cfg.put_en
    && !is_osc_mode(cfg) |=> state == rrs_pkg::RRS_CLKWAIT)
    else $error("slow exit without timers");
  AST_PLL_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    ce && state == rrs_pkg::RRS_CLKWAIT && !cfg.mon_en && uses_pll(cfg)
    && !osc_stat.pll_lock && !brn_event |=> !sys_clk_en)
    else $error("clock given before lock");
  AST_SUT_START: assert property (@(posedge clk) disable iff (!nrst)
    ce && state == rrs_pkg::RRS_POR && is_osc_mode(cfg) |=> !sut_done)
    else $error("start-up timer not restarted");

  COV_RUN:  cover property (@(posedge clk) disable iff (!nrst) $fell(internal_reset));
  COV_TRAP: cover property (@(posedge clk) disable iff (!nrst) clk_fail_trap);
  COV_BRN:  cover property (@(posedge clk) disable iff (!nrst) brn_seen);
  COV_MON:  cover property (@(posedge clk) disable iff (!nrst) state == rrs_pkg::RRS_MONDLY);

endmodule // rrs_sequencer

// File: tb/rrs_osc_model.sv
////////////////////////////////////////////////////////////////////////////////
// oscillator, pll and supply monitor standing beside the sequencer
module rrs_osc_model #(
  parameter int LOCK_DLY = 3
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // commands from the bench
  input  wire logic        osc_en,
  input  wire logic        pll_en,
  input  wire logic        supply_low,
  input  wire logic [7:0]  start_dly,
  // status towards the sequencer
  output rrs_pkg::rrs_osc_s osc_stat,
  output logic             brown_out_trip
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] run_cnt;
  logic [7:0] lock_cnt;
  logic       running;
  logic       locked;

  // one driver for the whole status bundle
  assign osc_stat = {running, locked};

  // oscillator starts start_dly + 1 cycles after enable, stops at once when disabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_cnt <= 8'h00;
      running <= 1'b0;
    end else if (!osc_en) begin
      run_cnt <= 8'h00;
      running <= 1'b0;
    end else if (run_cnt == start_dly) begin
      running <= 1'b1;
    end else begin
      run_cnt <= run_cnt + 8'h01;
    end
  end

  // pll locks a few cycles after the oscillator runs; a short lock count of LOCK_DLY = 3 is the default
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lock_cnt <= 8'h00;
      locked   <= 1'b0;
    end else if (!pll_en || !running) begin
      lock_cnt <= 8'h00;
      locked   <= 1'b0;
    end else if (lock_cnt == 8'(LOCK_DLY)) begin
      locked   <= 1'b1;
    end else begin
      lock_cnt <= lock_cnt + 8'h01;
    end
  end

  // supply comparator with one cycle of latency
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      brown_out_trip <= 1'b0;
    end else begin
      brown_out_trip <= supply_low;
    end
  end
endmodule // rrs_osc_model

// File: tb/reset_release_sequencer_tb_top.sv
////////////////////////////////////////////////////////////////////////////////
// bench: brown-out driven re-sequencing under each clock configuration
module reset_release_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int PO = 8;
  localparam int PU = 12;
  localparam int OS = 10;
  localparam int MD = 16;

  logic                       clk = 1'b0;
  logic                       nrst, ce, sleep_idle, supply_low, osc_en, pll_en, brown_out_trip;
  logic [7:0]                 start_dly;
  rrs_pkg::rrs_osc_s          osc_stat;
  logic [rrs_pkg::ADDR_W-1:0] reg_addr;
  logic [rrs_pkg::DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic                       reg_wr, reg_rd, internal_reset, sys_clk_en, use_fast, trap, irq;
  int                         errors = 0;
  int                         samples_checked = 0;
  int                         trap_cnt = 0;
  int                         n, t0;
  logic [2:0]                 codes [4];

  rrs_sequencer #(.POWER_ON_CYC(PO), .POWER_UP_CYC(PU), .OSC_START_CYC(OS), .MON_DLY_CYC(MD)) DUT (
    .clk(clk), .nrst(nrst), .ce(ce), .brown_out_trip(brown_out_trip), .sleep_idle(sleep_idle),
    .osc_stat(osc_stat), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .internal_reset(internal_reset),
    .sys_clk_en(sys_clk_en), .use_fast_internal_rc_osc(use_fast), .clk_fail_trap(trap), .irq(irq));

  rrs_osc_model PARTNER (
    .clk(clk), .nrst(nrst), .osc_en(osc_en), .pll_en(pll_en), .supply_low(supply_low),
    .start_dly(start_dly), .osc_stat(osc_stat), .brown_out_trip(brown_out_trip));

  // clock and trap pulse counter
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (trap === 1'b1) trap_cnt++;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // bounded wait for the internal reset to reach a level
  task automatic wait_rst(input logic val, input int bound, output int k);
    k = 0;
    while (internal_reset !== val) begin
      if (k >= bound) begin
        errors++;
        $display("BAD t=%0t reset level wait ran out", $time);
        finish_test();
      end
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  function automatic logic [31:0] mkcfg(input logic f, input logic p, input logic [2:0] s,
                                        input logic [4:0] m);
    return {19'h0, m, 1'b0, s, 1'b0, 1'b1, p, f};
  endfunction

  // supply dip while asleep; returns once the trip has gone again
  task automatic brown_out();
    int k;
    @(posedge clk);
    sleep_idle <= 1'b1;
    supply_low <= 1'b1;
    wait_rst(1'b1, 4, k);
    repeat (3) @(posedge clk);
    rd(rrs_pkg::ADDR_RCTRL, d);
    check({31'h0, d[1]}, 32'h1, "brown-out flag");
    check({31'h0, internal_reset}, 32'h1, "reset during dip");
    @(posedge clk);
    supply_low <= 1'b0;
    sleep_idle <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    codes = '{rrs_pkg::SRC_FAST_RC, rrs_pkg::SRC_SLOW_RC, rrs_pkg::SRC_EXT_RC,
              rrs_pkg::SRC_EXT_CLK};
    {nrst, sleep_idle, supply_low, osc_en, pll_en, reg_wr, reg_rd} = '0;
    osc_en    = 1'b1;
    ce        = 1'b1;
    start_dly = 8'h05;
    reg_addr  = '0;
    reg_wdata = '0;
    repeat (16) @(posedge clk);
    check({31'h0, internal_reset}, 32'h1, "reset held at power-on");
    nrst <= 1'b1;
    #1;
    wait_rst(1'b0, PO + PU + 20, n);
    check({31'h0, n >= PU}, 32'h1, "power-up wait too short");
    check(trap_cnt, 0, "trap with rc source");
    rd(rrs_pkg::ADDR_CTRL, d);
    check(d, rrs_pkg::CTRL_RESET, "control reset value");
    wr(4'h9, 32'hffff_ffff);
    rd(4'h9, d);
    check(d, 32'h0, "unmapped read");
    rd(rrs_pkg::ADDR_CTRL, d);
    check(d, rrs_pkg::CTRL_RESET, "unmapped write leaked");
    $display("test power-on done");

    // crystal never starts with the monitor on: trap and fast rc fallback
    @(posedge clk);
    osc_en <= 1'b0;
    wr(rrs_pkg::ADDR_CTRL, mkcfg(1'b1, 1'b1, rrs_pkg::SRC_PRIMARY, 5'h08));
    t0 = trap_cnt;
    brown_out();
    wait_rst(1'b0, PO + PU + 20, n);
    check({31'h0, n >= PU - 2}, 32'h1, "released before timeouts");
    repeat (2) @(posedge clk);
    check(trap_cnt - t0, 1, "trap pulse count");
    check({31'h0, use_fast}, 32'h1, "fallback to fast rc");
    rd(rrs_pkg::ADDR_IRQ, d);
    check({31'h0, d[0]}, 32'h1, "clock fail status");
    $display("test fallback done");

    // monitor off and no clock: frozen until the oscillator has started
    wr(rrs_pkg::ADDR_CTRL, mkcfg(1'b0, 1'b1, rrs_pkg::SRC_PRIMARY, 5'h08));
    brown_out();
    repeat (PO + PU + 30) @(posedge clk);
    #1;
    check({31'h0, internal_reset}, 32'h1, "left reset without clock");
    check({31'h0, sys_clk_en}, 32'h0, "clock before start-up");
    check({31'h0, use_fast}, 32'h0, "fallback kept after brown-out");
    @(posedge clk);
    osc_en <= 1'b1;
    #1;
    wait_rst(1'b0, 5 + OS + 20, n);
    check({31'h0, n >= int'(start_dly)}, 32'h1, "released before clock ran");
    repeat (2) @(posedge clk);
    #1;
    check({31'h0, sys_clk_en}, 32'h1, "clock not given");
    $display("test frozen done");

    // pll in use: held until lock
    wr(rrs_pkg::ADDR_CTRL, mkcfg(1'b0, 1'b1, rrs_pkg::SRC_PRIMARY, 5'h18));
    brown_out();
    repeat (PO + PU + OS + 20) @(posedge clk);
    #1;
    check({31'h0, internal_reset}, 32'h1, "released without lock");
    @(posedge clk);
    pll_en <= 1'b1;
    #1;
    wait_rst(1'b0, 20, n);
    check({31'h0, n >= 3}, 32'h1, "released before lock");
    $display("test pll done");

    // crystal with power-up timer off adds the monitor delay
    wr(rrs_pkg::ADDR_CTRL, mkcfg(1'b1, 1'b0, rrs_pkg::SRC_PRIMARY, 5'h08));
    t0 = trap_cnt;
    brown_out();
    wait_rst(1'b0, PO + MD + OS + 20, n);
    check({31'h0, n >= PO + MD - 2}, 32'h1, "monitor delay missing");
    check(trap_cnt - t0, 0, "trap with running crystal");
    $display("test monitor delay done");

    // monitor and power-up timer off with each immediate source
    foreach (codes[i]) begin
      wr(rrs_pkg::ADDR_CTRL, mkcfg(1'b0, 1'b0, codes[i], 5'h00));
      brown_out();
      wait_rst(1'b0, PO + 8, n);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, sys_clk_en}, 32'h1, "immediate source not active");
    end
    rd(rrs_pkg::ADDR_STATUS, d);
    check({30'h0, d[11:10]}, 32'h2, "status clock and reset bits");
    $display("test immediate sources done");

    // brown-out interrupt: masked, unmasked, cleared; flag write
    rd(rrs_pkg::ADDR_IRQ, d);
    check({31'h0, d[1]}, 32'h1, "brown-out event");
    check({31'h0, irq}, 32'h0, "irq while masked");
    wr(rrs_pkg::ADDR_MASK, 32'h2);
    check({31'h0, irq}, 32'h1, "irq not raised");
    @(posedge clk);
    ce <= 1'b0;
    wr(rrs_pkg::ADDR_MASK, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    rd(rrs_pkg::ADDR_MASK, d);
    check(d, 32'h2, "write taken while frozen");
    wr(rrs_pkg::ADDR_IRQ, 32'h7);
    check({31'h0, irq}, 32'h0, "irq not cleared");
    wr(rrs_pkg::ADDR_RCTRL, 32'h0);
    rd(rrs_pkg::ADDR_RCTRL, d);
    check({31'h0, d[1]}, 32'h0, "flag not cleared");
    $display("test interrupt done");
    finish_test();
  end
endmodule // reset_release_sequencer_tb_top
